/* File: shared/ssr_pkg.sv */
// constants and types of the status and event reporting block
`default_nettype none

package ssr_pkg;

	localparam int          ERRQ_DEPTH = 8;
	localparam logic [3:0]  ERRQ_LAST  = 4'h7;
	localparam logic [3:0]  ERRQ_FULL  = 4'h8;
	localparam logic [3:0]  CNT_RST    = 4'h0;
	localparam logic [2:0]  PTR_RST    = 3'h0;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [7:0]  STD_RST    = 8'h80;
	localparam logic [15:0] EN_USED    = 16'h7fff;
	localparam logic [7:0]  SRE_USED   = 8'hbf;
	localparam logic [7:0]  STD_USED   = 8'hfd;

	localparam int WB_VOLT = 0;
	localparam int WB_CURR = 1;
	localparam int WB_OVP  = 9;

	localparam int SB_ERRQ = 2;
	localparam int SB_WARN = 3;
	localparam int SB_OUT  = 4;
	localparam int SB_EVT  = 5;
	localparam int SB_SRV  = 6;
	localparam int SB_ACT  = 7;

	localparam int SE_DONE   = 0;
	localparam int SE_QUERY  = 2;
	localparam int SE_DEVICE = 3;
	localparam int SE_EXEC   = 4;
	localparam int SE_PARSE  = 5;
	localparam int SE_BUTTON = 6;

	// error codes in two's complement: -350, -100, -200, -300, -400, -500
	localparam logic signed [15:0] ERR_NONE = 16'sh0000;
	localparam logic signed [15:0] ERR_OVF  = 16'shfea2;
	localparam logic signed [15:0] PARSE_HI = 16'shff9c;
	localparam logic signed [15:0] EXEC_HI  = 16'shff38;
	localparam logic signed [15:0] DEV_HI   = 16'shfed4;
	localparam logic signed [15:0] QUERY_HI = 16'shfe70;
	localparam logic signed [15:0] QUERY_LO = 16'shfe0c;

	typedef enum logic [4:0] {
		OP_NONE   = 5'h00,
		OP_CLS    = 5'h01,
		OP_ARM    = 5'h02,
		OP_ESR_Q  = 5'h03,
		OP_ESE_W  = 5'h04,
		OP_ESE_Q  = 5'h05,
		OP_SRE_W  = 5'h06,
		OP_SRE_Q  = 5'h07,
		OP_STB_Q  = 5'h08,
		OP_WCND_Q = 5'h09,
		OP_WEVT_Q = 5'h0a,
		OP_WEN_W  = 5'h0b,
		OP_WEN_Q  = 5'h0c,
		OP_ACND_Q = 5'h0d,
		OP_AEVT_Q = 5'h0e,
		OP_AEN_W  = 5'h0f,
		OP_AEN_Q  = 5'h10,
		OP_PRESET = 5'h11,
		OP_ERR_Q  = 5'h12
	} ssr_op_type;

	typedef struct packed {
		logic        valid;
		ssr_op_type  op;
		logic [15:0] data;
	} ssr_cmd_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} ssr_rsp_type;

	typedef struct packed {
		logic button;
		logic ovp;
		logic curr;
		logic volt;
	} ssr_pins_type;

endpackage

`default_nettype wire

/* File: src/ssr_status_core.sv */
// status registers, summary byte and error queue of the instrument
`timescale 1ns/1ps
`default_nettype none

module ssr_status_core (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire ssr_pkg::ssr_cmd_type  cmd,
	input  wire logic                  msg_start,
	input  wire logic                  resp_put,
	input  wire logic                  resp_taken,
	input  wire logic                  err_put,
	input  wire logic signed [15:0]    err_code,
	input  wire logic                  ops_busy,
	input  wire ssr_pkg::ssr_pins_type pins,
	output var ssr_pkg::ssr_rsp_type   rsp,
	output logic [7:0]                 summary_byte,
	output logic                       srq
);

	// ----------------------------------------
	// command decode
	// ----------------------------------------

	wire logic is_cls    = cmd.valid && (cmd.op == ssr_pkg::OP_CLS);
	wire logic is_arm    = cmd.valid && (cmd.op == ssr_pkg::OP_ARM);
	wire logic is_esr_q  = cmd.valid && (cmd.op == ssr_pkg::OP_ESR_Q);
	wire logic is_ese_w  = cmd.valid && (cmd.op == ssr_pkg::OP_ESE_W);
	wire logic is_ese_q  = cmd.valid && (cmd.op == ssr_pkg::OP_ESE_Q);
	wire logic is_sre_w  = cmd.valid && (cmd.op == ssr_pkg::OP_SRE_W);
	wire logic is_sre_q  = cmd.valid && (cmd.op == ssr_pkg::OP_SRE_Q);
	wire logic is_stb_q  = cmd.valid && (cmd.op == ssr_pkg::OP_STB_Q);
	wire logic is_wcnd_q = cmd.valid && (cmd.op == ssr_pkg::OP_WCND_Q);
	wire logic is_wevt_q = cmd.valid && (cmd.op == ssr_pkg::OP_WEVT_Q);
	wire logic is_wen_w  = cmd.valid && (cmd.op == ssr_pkg::OP_WEN_W);
	wire logic is_wen_q  = cmd.valid && (cmd.op == ssr_pkg::OP_WEN_Q);
	wire logic is_acnd_q = cmd.valid && (cmd.op == ssr_pkg::OP_ACND_Q);
	wire logic is_aevt_q = cmd.valid && (cmd.op == ssr_pkg::OP_AEVT_Q);
	wire logic is_aen_w  = cmd.valid && (cmd.op == ssr_pkg::OP_AEN_W);
	wire logic is_aen_q  = cmd.valid && (cmd.op == ssr_pkg::OP_AEN_Q);
	wire logic is_preset = cmd.valid && (cmd.op == ssr_pkg::OP_PRESET);
	wire logic is_err_q  = cmd.valid && (cmd.op == ssr_pkg::OP_ERR_Q);

	wire logic clr_warn = is_wevt_q || is_cls;
	wire logic clr_act  = is_aevt_q || is_cls;
	wire logic clr_se   = is_esr_q || is_cls;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------

	ssr_pkg::ssr_pins_type sync1_reg;
	ssr_pkg::ssr_pins_type sync2_reg;
	logic                  btn_prev_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_reg    <= '0;
			sync2_reg    <= '0;
			btn_prev_reg <= 1'b0;
		end else begin
			sync1_reg    <= pins;
			sync2_reg    <= sync1_reg;
			btn_prev_reg <= sync2_reg.button;
		end
	end

	wire logic btn_rise = sync2_reg.button && !btn_prev_reg;

	// ----------------------------------------
	// warning and activity groups
	// ----------------------------------------

	logic [15:0] warn_cond_reg;
	logic [15:0] warn_cond_next;
	logic [15:0] warn_evt_reg;
	logic [15:0] warn_evt_next;
	logic [15:0] warn_en_reg;
	logic [15:0] warn_en_next;
	logic [15:0] act_evt_reg;
	logic [15:0] act_evt_next;
	logic [15:0] act_en_reg;
	logic [15:0] act_en_next;

	always_comb begin
		warn_cond_next                  = ssr_pkg::WORD_RST;
		warn_cond_next[ssr_pkg::WB_VOLT] = sync2_reg.volt;
		warn_cond_next[ssr_pkg::WB_CURR] = sync2_reg.curr;
		warn_cond_next[ssr_pkg::WB_OVP]  = sync2_reg.ovp;
	end

	wire logic [15:0] act_cond  = ssr_pkg::WORD_RST;
	wire logic [15:0] warn_rise = warn_cond_next & ~warn_cond_reg;

	// set wins over the read clear
	assign warn_evt_next = (warn_evt_reg & ~{16{clr_warn}}) | warn_rise;
	assign act_evt_next  = act_evt_reg & ~{16{clr_act}};

	assign warn_en_next = is_preset ? ssr_pkg::WORD_RST :
		is_wen_w ? (cmd.data & ssr_pkg::EN_USED) : warn_en_reg;
	assign act_en_next  = is_preset ? ssr_pkg::WORD_RST :
		is_aen_w ? (cmd.data & ssr_pkg::EN_USED) : act_en_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			warn_cond_reg <= ssr_pkg::WORD_RST;
			warn_evt_reg  <= ssr_pkg::WORD_RST;
			warn_en_reg   <= ssr_pkg::WORD_RST;
			act_evt_reg   <= ssr_pkg::WORD_RST;
			act_en_reg    <= ssr_pkg::WORD_RST;
		end else begin
			warn_cond_reg <= warn_cond_next;
			warn_evt_reg  <= warn_evt_next;
			warn_en_reg   <= warn_en_next;
			act_evt_reg   <= act_evt_next;
			act_en_reg    <= act_en_next;
		end
	end

	// ----------------------------------------
	// error queue
	// ----------------------------------------

	logic [15:0] errq_reg [ssr_pkg::ERRQ_DEPTH];
	logic [2:0]  wr_ptr_reg;
	logic [2:0]  rd_ptr_reg;
	logic [3:0]  cnt_reg;
	logic [3:0]  cnt_next;
	logic        ovf_reg;

	wire logic q_pop     = is_err_q && (cnt_reg != ssr_pkg::CNT_RST);
	wire logic q_push    = err_put && (err_code != ssr_pkg::ERR_NONE) && !ovf_reg;
	wire logic full_soon = (cnt_reg == ssr_pkg::ERRQ_LAST) && !q_pop;
	wire logic signed [15:0] q_data = full_soon ? ssr_pkg::ERR_OVF : err_code;
	wire logic ovf_next  = (ovf_reg && !q_pop) || (q_push && full_soon);

	assign cnt_next = cnt_reg + {3'h0, q_push} - {3'h0, q_pop};

	for (genvar i = 0; i < ssr_pkg::ERRQ_DEPTH; i++) begin : g_errq
		always_ff @(posedge mclk) begin
			if (rst) begin
				errq_reg[i] <= ssr_pkg::WORD_RST;
			end else if (q_push && (wr_ptr_reg == 3'(i))) begin
				errq_reg[i] <= q_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_ptr_reg <= ssr_pkg::PTR_RST;
			rd_ptr_reg <= ssr_pkg::PTR_RST;
			cnt_reg    <= ssr_pkg::CNT_RST;
			ovf_reg    <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + {2'h0, q_push};
			rd_ptr_reg <= rd_ptr_reg + {2'h0, q_pop};
			cnt_reg    <= cnt_next;
			ovf_reg    <= ovf_next;
		end
	end

	// error class to standard event bit
	wire logic cls_parse = q_push && (q_data <= ssr_pkg::PARSE_HI) && (q_data > ssr_pkg::EXEC_HI);
	wire logic cls_exec  = q_push && (q_data <= ssr_pkg::EXEC_HI) && (q_data > ssr_pkg::DEV_HI);
	wire logic cls_dev   = q_push && (q_data <= ssr_pkg::DEV_HI) && (q_data > ssr_pkg::QUERY_HI);
	wire logic cls_query = q_push && (q_data <= ssr_pkg::QUERY_HI) && (q_data > ssr_pkg::QUERY_LO);

	// ----------------------------------------
	// standard event register and masks
	// ----------------------------------------

	logic [7:0] se_reg;
	logic [7:0] se_next;
	logic [7:0] se_set;
	logic [7:0] ese_reg;
	logic [7:0] sre_reg;
	logic       arm_reg;
	logic       out_reg;

	wire logic ops_done = arm_reg && !ops_busy;

	always_comb begin
		se_set                     = ssr_pkg::BYTE_RST;
		se_set[ssr_pkg::SE_DONE]   = ops_done;
		se_set[ssr_pkg::SE_QUERY]  = cls_query;
		se_set[ssr_pkg::SE_DEVICE] = cls_dev;
		se_set[ssr_pkg::SE_EXEC]   = cls_exec;
		se_set[ssr_pkg::SE_PARSE]  = cls_parse;
		se_set[ssr_pkg::SE_BUTTON] = btn_rise;
	end

	// bit 1 forced low
	assign se_next = ((se_reg & ~{8{clr_se}}) | se_set) & ssr_pkg::STD_USED;

	// a new arm wins over completion, so it is not lost
	wire logic       arm_next = is_arm || (arm_reg && !ops_done);
	wire logic [7:0] ese_next = is_ese_w ? cmd.data[7:0] : ese_reg;
	wire logic [7:0] sre_next = is_sre_w ? (cmd.data[7:0] & ssr_pkg::SRE_USED) : sre_reg;
	wire logic out_next = resp_put || (out_reg && !resp_taken && !msg_start);

	always_ff @(posedge mclk) begin
		if (rst) begin
			se_reg  <= ssr_pkg::STD_RST;
			ese_reg <= ssr_pkg::BYTE_RST;
			sre_reg <= ssr_pkg::BYTE_RST;
			arm_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			se_reg  <= se_next;
			ese_reg <= ese_next;
			sre_reg <= sre_next;
			arm_reg <= arm_next;
			out_reg <= out_next;
		end
	end

	// ----------------------------------------
	// summary byte and service request
	// ----------------------------------------

	logic [7:0] sb_next;
	logic [7:0] summary_reg;
	logic       srq_reg;

	always_comb begin
		sb_next                  = ssr_pkg::BYTE_RST;
		sb_next[ssr_pkg::SB_ERRQ] = (cnt_reg != ssr_pkg::CNT_RST);
		sb_next[ssr_pkg::SB_WARN] = |(warn_evt_reg & warn_en_reg);
		sb_next[ssr_pkg::SB_OUT]  = out_reg;
		sb_next[ssr_pkg::SB_EVT]  = |(se_reg & ese_reg);
		sb_next[ssr_pkg::SB_ACT]  = |(act_evt_reg & act_en_reg);
		sb_next[ssr_pkg::SB_SRV]  = |(sb_next & sre_reg);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			summary_reg <= ssr_pkg::BYTE_RST;
			srq_reg     <= 1'b0;
		end else begin
			summary_reg <= sb_next;
			srq_reg     <= sb_next[ssr_pkg::SB_SRV];
		end
	end

	// ----------------------------------------
	// query answers
	// ----------------------------------------

	ssr_pkg::ssr_rsp_type rsp_reg;

	wire logic rsp_valid_next = is_esr_q || is_ese_q || is_sre_q || is_stb_q ||
		is_wcnd_q || is_wevt_q || is_wen_q || is_acnd_q || is_aevt_q ||
		is_aen_q || is_err_q;

	wire logic [15:0] rsp_data_next =
		is_esr_q  ? {8'h00, se_reg} :
		is_ese_q  ? {8'h00, ese_reg} :
		is_sre_q  ? {8'h00, sre_reg} :
		is_stb_q  ? {8'h00, summary_reg} :
		is_wcnd_q ? warn_cond_reg :
		is_wevt_q ? warn_evt_reg :
		is_wen_q  ? warn_en_reg :
		is_acnd_q ? act_cond :
		is_aevt_q ? act_evt_reg :
		is_aen_q  ? act_en_reg :
		q_pop     ? errq_reg[rd_ptr_reg] :
		ssr_pkg::WORD_RST;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.valid <= rsp_valid_next;
			rsp_reg.data  <= rsp_data_next;
		end
	end

	assign rsp          = rsp_reg;
	assign summary_byte = summary_reg;
	assign srq          = srq_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_arm_idle;
		is_arm ##1 !ops_busy;
	endsequence

	property p_cond_live;
		$rose(sync2_reg.ovp) |=> warn_cond_reg[ssr_pkg::WB_OVP] && warn_evt_reg[ssr_pkg::WB_OVP];
	endproperty
	a_cond_live: assert property (p_cond_live) else $error("condition edge not seen");

	property p_evt_hold;
		!clr_warn |=> ((warn_evt_reg & $past(warn_evt_reg)) == $past(warn_evt_reg));
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("event bit lost");

	property p_evt_read;
		is_wevt_q |=> rsp_reg.valid && (rsp_reg.data == $past(warn_evt_reg)) &&
			(warn_evt_reg == $past(warn_rise));
	endproperty
	a_evt_read: assert property (p_evt_read) else $error("event read wrong");

	property p_cls;
		is_cls |=> (se_reg == $past(se_set & ssr_pkg::STD_USED));
	endproperty
	a_cls: assert property (p_cls) else $error("clear status missed");

	property p_cond_q;
		is_wcnd_q |=> (rsp_reg.data == $past(warn_cond_reg)) && rsp_reg.valid;
	endproperty
	a_cond_q: assert property (p_cond_q) else $error("condition query wrong");

	property p_act_zero;
		(act_evt_reg == ssr_pkg::WORD_RST) && !summary_reg[ssr_pkg::SB_ACT];
	endproperty
	a_act_zero: assert property (p_act_zero) else $error("activity bit set");

	property p_sb_low;
		(summary_reg[1:0] == 2'h0) && !se_reg[1];
	endproperty
	a_sb_low: assert property (p_sb_low) else $error("unused bit set");

	property p_errq_flag;
		##1 summary_reg[ssr_pkg::SB_ERRQ] == $past(cnt_reg != ssr_pkg::CNT_RST);
	endproperty
	a_errq_flag: assert property (p_errq_flag) else $error("error flag wrong");

	property p_rqs;
		srq_reg == summary_reg[ssr_pkg::SB_SRV];
	endproperty
	a_rqs: assert property (p_rqs) else $error("service request mismatch");

	property p_ops_done;
		s_arm_idle |=> se_reg[ssr_pkg::SE_DONE];
	endproperty
	a_ops_done: assert property (p_ops_done) else $error("operation complete missed");

	property p_ovf;
		q_push && full_soon |=> ovf_reg && (cnt_reg == ssr_pkg::ERRQ_FULL) &&
			se_reg[ssr_pkg::SE_DEVICE];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not recorded");

	property p_parse_cls;
		q_push && (q_data == ssr_pkg::PARSE_HI) |=> se_reg[ssr_pkg::SE_PARSE];
	endproperty
	a_parse_cls: assert property (p_parse_cls) else $error("command error class missed");

	property p_out_clear;
		msg_start && !resp_put |=> !out_reg ##1 !summary_reg[ssr_pkg::SB_OUT];
	endproperty
	a_out_clear: assert property (p_out_clear) else $error("output queue not cleared");

	property p_mask15;
		!warn_en_reg[15] && !act_en_reg[15];
	endproperty
	a_mask15: assert property (p_mask15) else $error("mask bit 15 set");

	property p_preset;
		is_preset |=> (warn_en_reg == ssr_pkg::WORD_RST) && (act_en_reg == ssr_pkg::WORD_RST);
	endproperty
	a_preset: assert property (p_preset) else $error("preset missed");

endmodule

`default_nettype wire

/* File: verification/ssr_ctrl_model.sv */
// remote controller model driving the command bus of the status block
`timescale 1ns/1ps
`default_nettype none

module ssr_ctrl_model (
	input  wire logic                 mclk,
	input  wire ssr_pkg::ssr_rsp_type rsp,
	output var ssr_pkg::ssr_cmd_type  cmd,
	output var logic                  msg_start,
	output var logic                  resp_taken
);

	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial begin
		cmd        = '0;
		msg_start  = 1'b0;
		resp_taken = 1'b0;
	end

	// ----------------------------------------
	// command and query cycles
	// ----------------------------------------
	// one command for one cycle, idle data inverted so no stale value stays
	task automatic send(input ssr_pkg::ssr_op_type op, input logic [15:0] data);
		@(posedge mclk);
		cmd <= {1'b1, op, data};
		@(posedge mclk);
		cmd <= {1'b0, ssr_pkg::OP_NONE, ~data};
		#1;
	endtask

	// answer sampled in the cycle after the request
	task automatic ask(input ssr_pkg::ssr_op_type op, output logic v, output logic [15:0] d);
		send(op, 16'h0000);
		v = rsp.valid;
		d = rsp.data;
	endtask

	// ----------------------------------------
	// message framing
	// ----------------------------------------
	// response read before the next message is sent
	task automatic take();
		@(posedge mclk);
		resp_taken <= 1'b1;
		@(posedge mclk);
		resp_taken <= 1'b0;
		#1;
	endtask

	// new message after a terminator
	task automatic msg();
		@(posedge mclk);
		msg_start <= 1'b1;
		@(posedge mclk);
		msg_start <= 1'b0;
		#1;
	endtask

endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// self-checking testbench of the status and event reporting block
`timescale 1ns/1ps
`default_nettype none

module testbench;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic                  mclk;
	logic                  rst;
	ssr_pkg::ssr_cmd_type  cmd;
	logic                  msg_start;
	logic                  resp_put;
	logic                  resp_taken;
	logic                  err_put;
	logic signed [15:0]    err_code;
	logic                  ops_busy;
	ssr_pkg::ssr_pins_type pins;
	ssr_pkg::ssr_rsp_type  rsp;
	logic [7:0]            summary_byte;
	logic                  srq;
	int                    fail_count;
	int                    checks_done;

	// ----------------------------------------
	// design and controller model
	// ----------------------------------------
	ssr_status_core dut (
		.mclk         (mclk),
		.rst          (rst),
		.cmd          (cmd),
		.msg_start    (msg_start),
		.resp_put     (resp_put),
		.resp_taken   (resp_taken),
		.err_put      (err_put),
		.err_code     (err_code),
		.ops_busy     (ops_busy),
		.pins         (pins),
		.rsp          (rsp),
		.summary_byte (summary_byte),
		.srq          (srq)
	);

	ssr_ctrl_model m (
		.mclk       (mclk),
		.rsp        (rsp),
		.cmd        (cmd),
		.msg_start  (msg_start),
		.resp_taken (resp_taken)
	);

	always #2 mclk = ~mclk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_sim();
		$display("checks done %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic q(input ssr_pkg::ssr_op_type op, input logic [15:0] exp);
		logic        v;
		logic [15:0] d;
		m.ask(op, v, d);
		check({15'h0000, v}, 16'h0001);
		check(d, exp);
	endtask

	task automatic sb(input logic [7:0] exp);
		tick(3);
		check({8'h00, summary_byte}, {8'h00, exp});
		check({15'h0000, srq}, {15'h0000, exp[6]});
	endtask

	task automatic push(input logic signed [15:0] code);
		@(posedge mclk);
		err_put  <= 1'b1;
		err_code <= code;
		@(posedge mclk);
		err_put  <= 1'b0;
		#1;
	endtask

	task automatic pulse_put();
		@(posedge mclk);
		resp_put <= 1'b1;
		@(posedge mclk);
		resp_put <= 1'b0;
		#1;
	endtask

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		mclk        = 1'b0;
		rst         = 1'b1;
		resp_put    = 1'b0;
		err_put     = 1'b0;
		err_code    = 16'sh0000;
		ops_busy    = 1'b0;
		pins        = '0;
		fail_count  = 0;
		checks_done = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		tick(1);
		sb(8'h00);
		q(ssr_pkg::OP_ESR_Q, 16'h0080);
		q(ssr_pkg::OP_ESR_Q, 16'h0000);
		// condition and event registers
		@(posedge mclk);
		pins.volt <= 1'b1;
		pins.curr <= 1'b1;
		pins.ovp  <= 1'b1;
		tick(5);
		q(ssr_pkg::OP_WCND_Q, 16'h0203);
		q(ssr_pkg::OP_WCND_Q, 16'h0203);
		@(posedge mclk);
		pins <= '0;
		tick(5);
		q(ssr_pkg::OP_WCND_Q, 16'h0000);
		q(ssr_pkg::OP_WEVT_Q, 16'h0203);
		q(ssr_pkg::OP_WEVT_Q, 16'h0000);
		// masks and summary byte
		m.send(ssr_pkg::OP_WEN_W, 16'hffff);
		q(ssr_pkg::OP_WEN_Q, 16'h7fff);
		@(posedge mclk);
		pins.volt <= 1'b1;
		tick(5);
		sb(8'h08);
		m.send(ssr_pkg::OP_SRE_W, 16'hffff);
		q(ssr_pkg::OP_SRE_Q, 16'h00bf);
		sb(8'h48);
		q(ssr_pkg::OP_STB_Q, 16'h0048);
		m.send(ssr_pkg::OP_PRESET, 16'h0000);
		q(ssr_pkg::OP_WEN_Q, 16'h0000);
		sb(8'h00);
		m.send(ssr_pkg::OP_AEN_W, 16'hffff);
		q(ssr_pkg::OP_AEN_Q, 16'h7fff);
		q(ssr_pkg::OP_ACND_Q, 16'h0000);
		q(ssr_pkg::OP_AEVT_Q, 16'h0000);
		sb(8'h00);
		// output queue
		pulse_put();
		sb(8'h50);
		m.take();
		sb(8'h00);
		pulse_put();
		m.msg();
		sb(8'h00);
		// error queue
		push(-16'sd100);
		push(-16'sd200);
		push(-16'sd300);
		push(-16'sd410);
		push(16'sh0000);
		sb(8'h44);
		q(ssr_pkg::OP_ESR_Q, 16'h003c);
		q(ssr_pkg::OP_ERR_Q, 16'hff9c);
		q(ssr_pkg::OP_ERR_Q, 16'hff38);
		q(ssr_pkg::OP_ERR_Q, 16'hfed4);
		q(ssr_pkg::OP_ERR_Q, 16'hfe66);
		q(ssr_pkg::OP_ERR_Q, 16'h0000);
		sb(8'h00);
		for (int i = 0; i < 9; i++) begin
			push(-16'sd100);
		end
		for (int i = 0; i < 7; i++) begin
			q(ssr_pkg::OP_ERR_Q, 16'hff9c);
		end
		q(ssr_pkg::OP_ERR_Q, 16'hfea2);
		q(ssr_pkg::OP_ERR_Q, 16'h0000);
		q(ssr_pkg::OP_ESR_Q, 16'h0028);
		// operation complete and event summary
		m.send(ssr_pkg::OP_ESE_W, 16'h0001);
		q(ssr_pkg::OP_ESE_Q, 16'h0001);
		@(posedge mclk);
		ops_busy <= 1'b1;
		m.send(ssr_pkg::OP_ARM, 16'h0000);
		tick(5);
		q(ssr_pkg::OP_ESR_Q, 16'h0000);
		@(posedge mclk);
		ops_busy <= 1'b0;
		sb(8'h60);
		q(ssr_pkg::OP_ESR_Q, 16'h0001);
		// arm with nothing pending completes at once
		m.send(ssr_pkg::OP_ARM, 16'h0000);
		q(ssr_pkg::OP_ESR_Q, 16'h0001);
		// local button and clear status
		@(posedge mclk);
		pins.button <= 1'b1;
		tick(8);
		q(ssr_pkg::OP_ESR_Q, 16'h0040);
		@(posedge mclk);
		pins <= '0;
		tick(5);
		@(posedge mclk);
		pins.button <= 1'b1;
		pins.volt   <= 1'b1;
		tick(8);
		m.send(ssr_pkg::OP_CLS, 16'h0000);
		q(ssr_pkg::OP_WEVT_Q, 16'h0000);
		q(ssr_pkg::OP_ESR_Q, 16'h0000);
		end_sim();
	end

endmodule

`default_nettype wire
